// file: verilog/aclp_defines.svh
// Named offsets, codes and limits of the auto class power limit block.
// Assumes inclusion by bare name from the package and the design file.
`ifndef ACLP_DEFINES_SVH
`define ACLP_DEFINES_SVH

// ==========================================
// Register indices (byte address is index times four)
`define ACLP_IDX_CLASS0 8'h4c
`define ACLP_IDX_CTRL 8'h50
`define ACLP_IDX_PWR0 8'h51
`define ACLP_IDX_LIM2_0 8'h58
`define ACLP_IDX_LIM4_0 8'h5c
`define ACLP_CTRL_RST 8'h00
`define ACLP_REQ_LSB 4
`define ACLP_AAC_LSB 0
`define ACLP_LIM2_RST 8'hff
`define ACLP_LIM4_RST 9'h1ff

// ==========================================
// Class codes
`define ACLP_CLS_UNKNOWN 4'h0
`define ACLP_CLS_1 4'h1
`define ACLP_CLS_2 4'h2
`define ACLP_CLS_3 4'h3
`define ACLP_CLS_4 4'h4
`define ACLP_CLS_0 4'h6
`define ACLP_CLS_5SS 4'h8
`define ACLP_CLS_6SS 4'h9
`define ACLP_CLS_7SS 4'ha
`define ACLP_CLS_8SS 4'hb
`define ACLP_CLS_5DS 4'hd

// ==========================================
// Class power ceilings in half-watt steps
`define ACLP_MAX_CLS1 9'h008
`define ACLP_MAX_CLS2 9'h00e
`define ACLP_MAX_CLS3 9'h01f
`define ACLP_MAX_CLS4 9'h03c
`define ACLP_MAX_CLS5 9'h05a
`define ACLP_MAX_CLS6 9'h078
`define ACLP_MAX_CLS7 9'h096
`define ACLP_MAX_CLS8 9'h0b4
`define ACLP_MAX_NONE 9'h1ff

// ==========================================
// Margin bands: upper bound of each band and its margin, half-watt steps
`define ACLP_BAND1 8'h25
`define ACLP_BAND2 8'h34
`define ACLP_BAND3 8'h4a
`define ACLP_BAND4 8'h5a
`define ACLP_BAND5 8'h67
`define ACLP_BAND6 8'h74
`define ACLP_BAND7 8'h7e
`define ACLP_BAND8 8'h88
`define ACLP_BAND9 8'h92
`define ACLP_MRG1 5'h01
`define ACLP_MRG2 5'h02
`define ACLP_MRG3 5'h04
`define ACLP_MRG4 5'h06
`define ACLP_MRG5 5'h08
`define ACLP_MRG6 5'h0a
`define ACLP_MRG7 5'h0c
`define ACLP_MRG8 5'h0e
`define ACLP_MRG9 5'h10
`define ACLP_MRG10 5'h12

`endif

// file: verilog/aclp_pkg.sv
// Types shared by the auto class power limit block.
// Assumes the defines header sits on the include path.
package aclp_pkg;
  `include "aclp_defines.svh"

  typedef logic [3:0] aclp_class_t;
  typedef logic [6:0] aclp_pwr_t;
  typedef logic [7:0] aclp_lim2_t;
  typedef logic [8:0] aclp_lim4_t;

  // Register selected by a bus address
  typedef enum {
    ACLP_SEL_NONE,
    ACLP_SEL_CLASS,
    ACLP_SEL_CTRL,
    ACLP_SEL_PWR,
    ACLP_SEL_LIM2,
    ACLP_SEL_LIM4
  } aclp_sel_t;
endpackage

// file: verilog/aclp_ctrl.sv
// Class reporting and auto class power limit control for four channels.
// Assumes a classic Wishbone master on one 40 MHz clock and a measurement
// engine that answers each start pulse with one done pulse and a result.
//
// The Wishbone slave port was left to the implementer.
`timescale 1ns/1ps
`include "aclp_defines.svh"

// Overview of operation
// - Previous class codes are kept only if legal, else reported unknown.
// - Assigned class is the class granted at power on by allocation.
// - Four-pair single signature: both channels share class; done flag on classified one.
// - Four-pair dual signature: each channel reports its own assigned class.
// - A class 0 load gets assigned class 3 when powered.
// - Manual or diagnostic power on yields no assigned class; host sets policing.
// - Three-finger prior class stored for 15.4 W, one finger, semi-auto discovery.
// - A set measurement request starts the measurement well within 10 ms.
// - Request bit clears after the power result is updated, within 1 ms.
// - Auto adjust bit lets the device set power limits; otherwise host does.
// - Requests set before turn on are ignored and cleared at turn on.
// - Auto adjusted limits are applied within 5 ms after measurement ends.
// - New limit is measured power plus a banded margin, 0.5 W to 9 W.
// - Two-pair or dual signature loads update only per channel two-pair limits.
// - Single signature four-pair loads update the four-pair limit from the sum.
// - Four-pair limit updates even if only one auto adjust bit is set.
// - Four-pair single signature needs both requests set to measure.
// - Limits stay unchanged if power plus margin exceeds the class range.
// - Class register holds previous class low, assigned class high nibble.
// - Class bits clear when the channel is turned off.
// - Measured power is a 7-bit count in half-watt steps.
module aclp_ctrl (
  input wire logic clk,
  input wire logic rst_b,
  // Wishbone slave
  input wire logic wbCyc,
  input wire logic wbStb,
  input wire logic wbWe,
  input wire logic [9:0] wbAdr,
  input wire logic [3:0] wbSel,
  input wire logic [31:0] wbDatIn,
  output logic [31:0] wbDatOut,
  output logic wbAck,
  // Channel state from the port controller
  input wire logic [3:0] chanOn,
  input wire logic [3:0] grantStb,
  input wire logic [15:0] grantCode,
  input wire logic [3:0] reqClassZero,
  input wire logic [3:0] manualMode,
  input wire logic [3:0] semiAuto,
  input wire logic [3:0] discovery_enable,
  input wire logic [3:0] classEnable,
  input wire logic [3:0] alloc15w,
  input wire logic [3:0] oneFinger,
  input wire logic [15:0] threeFingerCode,
  input wire logic [1:0] fourPairPort,
  input wire logic [1:0] singleSig,
  // Auto class measurement engine
  output logic [3:0] measStart,
  input wire logic [3:0] measDone,
  input wire logic [27:0] measPower,
  // Results
  output logic [3:0] class_done_flag,
  output logic [31:0] two_pair_power_limit,
  output logic [17:0] four_pair_power_limit
);
  import aclp_pkg::*;

  // ==========================================
  // Helper functions

  // Bus address to register select
  function automatic aclp_sel_t regSel(input logic [7:0] idx);
    if (idx >= `ACLP_IDX_CLASS0 && idx < `ACLP_IDX_CTRL) begin
      regSel = ACLP_SEL_CLASS;
    end else if (idx == `ACLP_IDX_CTRL) begin
      regSel = ACLP_SEL_CTRL;
    end else if (idx >= `ACLP_IDX_PWR0 && idx < 8'(`ACLP_IDX_PWR0 + 8'h04)) begin
      regSel = ACLP_SEL_PWR;
    end else if (idx >= `ACLP_IDX_LIM2_0 && idx < `ACLP_IDX_LIM4_0) begin
      regSel = ACLP_SEL_LIM2;
    end else if (idx >= `ACLP_IDX_LIM4_0 && idx < 8'(`ACLP_IDX_LIM4_0 + 8'h02)) begin
      regSel = ACLP_SEL_LIM4;
    end else begin
      regSel = ACLP_SEL_NONE;
    end
  endfunction

  // Legal previous class codes, others report unknown
  function automatic aclp_class_t priorLegal(input aclp_class_t c);
    unique case (c)
      `ACLP_CLS_UNKNOWN, `ACLP_CLS_1, `ACLP_CLS_2, `ACLP_CLS_3, `ACLP_CLS_4,
      `ACLP_CLS_0, `ACLP_CLS_5SS, `ACLP_CLS_6SS, `ACLP_CLS_7SS, `ACLP_CLS_8SS,
      `ACLP_CLS_5DS: priorLegal = c;
      default: priorLegal = `ACLP_CLS_UNKNOWN;
    endcase
  endfunction

  // Class power ceiling in half-watt steps; unknown has no ceiling
  function automatic aclp_lim4_t classMax(input aclp_class_t c);
    unique case (c)
      `ACLP_CLS_1: classMax = `ACLP_MAX_CLS1;
      `ACLP_CLS_2: classMax = `ACLP_MAX_CLS2;
      `ACLP_CLS_3: classMax = `ACLP_MAX_CLS3;
      `ACLP_CLS_4: classMax = `ACLP_MAX_CLS4;
      `ACLP_CLS_5SS, `ACLP_CLS_5DS: classMax = `ACLP_MAX_CLS5;
      `ACLP_CLS_6SS: classMax = `ACLP_MAX_CLS6;
      `ACLP_CLS_7SS: classMax = `ACLP_MAX_CLS7;
      `ACLP_CLS_8SS: classMax = `ACLP_MAX_CLS8;
      default: classMax = `ACLP_MAX_NONE;
    endcase
  endfunction

  // Margin by measured power band, half-watt steps
  function automatic logic [4:0] margin(input logic [7:0] p);
    if (p < `ACLP_BAND1) margin = `ACLP_MRG1;
    else if (p <= `ACLP_BAND2) margin = `ACLP_MRG2;
    else if (p <= `ACLP_BAND3) margin = `ACLP_MRG3;
    else if (p <= `ACLP_BAND4) margin = `ACLP_MRG4;
    else if (p <= `ACLP_BAND5) margin = `ACLP_MRG5;
    else if (p <= `ACLP_BAND6) margin = `ACLP_MRG6;
    else if (p <= `ACLP_BAND7) margin = `ACLP_MRG7;
    else if (p <= `ACLP_BAND8) margin = `ACLP_MRG8;
    else if (p <= `ACLP_BAND9) margin = `ACLP_MRG9;
    else margin = `ACLP_MRG10;
  endfunction

  // ==========================================
  // State

  logic [7:0] ctrl_reg;
  logic ack_reg;
  logic [31:0] rdat_reg;
  logic [3:0] chanOnDly_reg;
  logic [3:0] busy_reg;
  logic [3:0] clearPend_reg;
  logic [3:0] measStart_reg;
  logic [3:0] classDone_reg;
  logic [1:0] pairPend_reg;
  aclp_class_t granted_reg [4];
  aclp_class_t prior_reg [4];
  aclp_pwr_t acPower_reg [4];
  aclp_lim2_t lim2_reg [4];
  aclp_lim4_t lim4_reg [2];
  aclp_sel_t sel;
  logic [1:0] subIdx;
  logic busWrite;
  logic [3:0] req;
  logic [3:0] aac;
  logic [3:0] turnOn;
  logic [3:0] canStart;
  logic [3:0] done;
  aclp_class_t grantNext [4];

  assign sel = regSel(wbAdr[9:2]);
  assign subIdx = wbAdr[3:2] - 2'(regSel(wbAdr[9:2]) == ACLP_SEL_PWR);
  assign busWrite = wbCyc & wbStb & wbWe & ack_reg & wbSel[0];
  assign req = ctrl_reg[`ACLP_REQ_LSB +: 4];
  assign aac = ctrl_reg[`ACLP_AAC_LSB +: 4];
  assign turnOn = chanOn & ~chanOnDly_reg;
  assign done = measDone & busy_reg;

  // ==========================================
  // Wishbone slave: ack one cycle after request, drops the cycle after

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= wbCyc & wbStb & ~ack_reg;
    end
  end

  // Read data captured as ack rises; unmapped reads return zero
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rdat_reg <= 32'h0000_0000;
    end else if (wbCyc & wbStb & ~ack_reg) begin
      unique case (sel)
        ACLP_SEL_CLASS: rdat_reg <= {24'h00_0000, granted_reg[subIdx], prior_reg[subIdx]};
        ACLP_SEL_CTRL: rdat_reg <= {24'h00_0000, ctrl_reg};
        ACLP_SEL_PWR: rdat_reg <= {25'h000_0000, acPower_reg[subIdx]};
        ACLP_SEL_LIM2: rdat_reg <= {24'h00_0000, lim2_reg[subIdx]};
        ACLP_SEL_LIM4: rdat_reg <= {23'h00_0000, lim4_reg[subIdx[0]]};
        ACLP_SEL_NONE: rdat_reg <= 32'h0000_0000;
      endcase
    end
  end

  assign wbAck = ack_reg;
  assign wbDatOut = rdat_reg;

  // ==========================================
  // Control register: host sets, hardware clears; a host write wins

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ctrl_reg <= `ACLP_CTRL_RST;
    end else if (busWrite && sel == ACLP_SEL_CTRL) begin
      ctrl_reg <= wbDatIn[7:0];
    end else begin
      ctrl_reg[`ACLP_REQ_LSB +: 4] <= req & ~turnOn & ~clearPend_reg;
    end
  end

  // Turn-on edge detection
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      chanOnDly_reg <= 4'h0;
    end else begin
      chanOnDly_reg <= chanOn;
    end
  end

  // ==========================================
  // Per-channel class reporting and measurement control

  genvar ch;
  generate
    for (ch = 0; ch < 4; ch++) begin : gChan
      localparam int PART = ch ^ 1;
      localparam int PAIR = ch / 2;
      logic ss;
      logic [7:0] sum2;
      assign ss = fourPairPort[PAIR] & singleSig[PAIR];
      assign sum2 = 8'({1'b0, acPower_reg[ch]}) + 8'(margin({1'b0, acPower_reg[ch]}));

      // Class granted on this channel's own power on
      always_comb begin
        if (manualMode[ch]) begin
          grantNext[ch] = `ACLP_CLS_UNKNOWN;
        end else if (reqClassZero[ch]) begin
          grantNext[ch] = `ACLP_CLS_3;
        end else begin
          grantNext[ch] = (grantCode[4*ch +: 4] == `ACLP_CLS_0) ? `ACLP_CLS_UNKNOWN
                          : priorLegal(grantCode[4*ch +: 4]); // no assigned class 0
        end
      end

      // Assigned class, shared across a single signature pair
      always_ff @(posedge clk) begin
        if (!rst_b) begin
          granted_reg[ch] <= `ACLP_CLS_UNKNOWN;
        end else if (!chanOn[ch]) begin
          granted_reg[ch] <= `ACLP_CLS_UNKNOWN;
        end else if (grantStb[ch]) begin
          granted_reg[ch] <= grantNext[ch];
        end else if (ss && grantStb[PART]) begin
          granted_reg[ch] <= grantNext[PART];
        end
      end

      // Previous class from the three-finger cycle before turn on
      always_ff @(posedge clk) begin
        if (!rst_b) begin
          prior_reg[ch] <= `ACLP_CLS_UNKNOWN;
        end else if (!chanOn[ch]) begin
          prior_reg[ch] <= `ACLP_CLS_UNKNOWN;
        end else if (grantStb[ch] && alloc15w[ch] && oneFinger[ch] && semiAuto[ch]
                     && discovery_enable[ch] && classEnable[ch]) begin
          prior_reg[ch] <= priorLegal(threeFingerCode[4*ch +: 4]);
        end
      end

      // Start needs an on channel, and both requests on a single signature pair
      assign canStart[ch] = req[ch] & chanOn[ch] & ~busy_reg[ch] & ~clearPend_reg[ch]
                            & ~turnOn[ch]
                            & (~ss | (req[PART] & chanOn[PART] & ~busy_reg[PART]
                                      & ~clearPend_reg[PART] & ~turnOn[PART]));

      // Measurement busy, start pulse and request clear scheduling
      always_ff @(posedge clk) begin
        if (!rst_b) begin
          busy_reg[ch] <= 1'b0;
          clearPend_reg[ch] <= 1'b0;
          measStart_reg[ch] <= 1'b0;
        end else begin
          busy_reg[ch] <= canStart[ch] | (busy_reg[ch] & ~measDone[ch] & chanOn[ch]);
          clearPend_reg[ch] <= done[ch];
          measStart_reg[ch] <= canStart[ch];
        end
      end

      // Measured power result
      always_ff @(posedge clk) begin
        if (!rst_b) begin
          acPower_reg[ch] <= 7'h00;
        end else if (done[ch]) begin
          acPower_reg[ch] <= measPower[7*ch +: 7];
        end
      end

      // Two-pair limit: host write or auto adjust one cycle after result
      always_ff @(posedge clk) begin
        if (!rst_b) begin
          lim2_reg[ch] <= `ACLP_LIM2_RST;
        end else if (clearPend_reg[ch] && aac[ch] && !ss
                     && 9'(sum2) <= classMax(granted_reg[ch])) begin
          lim2_reg[ch] <= sum2;
        end else if (busWrite && sel == ACLP_SEL_LIM2 && subIdx == 2'(ch)) begin
          lim2_reg[ch] <= wbDatIn[7:0];
        end
      end

      assign two_pair_power_limit[8*ch +: 8] = lim2_reg[ch];
    end
  endgenerate

  // ==========================================
  // Four-pair limits from the summed pair measurement

  genvar pr;
  generate
    for (pr = 0; pr < 2; pr++) begin : gPair
      logic [7:0] sumP;
      logic [8:0] sum4;
      logic ssPair;
      assign ssPair = fourPairPort[pr] & singleSig[pr];
      assign sumP = 8'(acPower_reg[2*pr]) + 8'(acPower_reg[2*pr+1]);
      assign sum4 = 9'(sumP) + 9'(margin(sumP));

      // Pending until both channels of the pair have finished
      always_ff @(posedge clk) begin
        if (!rst_b) begin
          pairPend_reg[pr] <= 1'b0;
        end else if (|done[2*pr +: 2]) begin
          pairPend_reg[pr] <= ssPair;
        end else if (!(|busy_reg[2*pr +: 2])) begin
          pairPend_reg[pr] <= 1'b0;
        end
      end

      always_ff @(posedge clk) begin
        if (!rst_b) begin
          lim4_reg[pr] <= `ACLP_LIM4_RST;
        end else if (pairPend_reg[pr] && !(|busy_reg[2*pr +: 2]) && ssPair
                     && (|aac[2*pr +: 2])
                     && sum4 <= classMax(granted_reg[2*pr])) begin
          lim4_reg[pr] <= sum4;
        end else if (busWrite && sel == ACLP_SEL_LIM4 && subIdx[0] == 1'(pr)
                     && subIdx[1] == 1'b0) begin
          lim4_reg[pr] <= {wbSel[1] ? wbDatIn[8] : lim4_reg[pr][8], wbDatIn[7:0]};
        end
      end

      assign four_pair_power_limit[9*pr +: 9] = lim4_reg[pr];
    end
  endgenerate

  // ==========================================
  // Class done flag only on the channel that was classified

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      classDone_reg <= 4'h0;
    end else begin
      classDone_reg <= grantStb & chanOn;
    end
  end

  assign class_done_flag = classDone_reg;
  assign measStart = measStart_reg;

endmodule // aclp_ctrl

// file: test/aclp_ctrl_asserts.sv
// Checker of the auto class power limit block at its ports.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ps
// ==========================================
// Checker
module aclp_ctrl_asserts (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic wbCyc,
  input wire logic wbStb,
  input wire logic wbWe,
  input wire logic [9:0] wbAdr,
  input wire logic [31:0] wbDatOut,
  input wire logic wbAck,
  input wire logic [3:0] chanOn,
  input wire logic [3:0] grantStb,
  input wire logic [1:0] fourPairPort,
  input wire logic [1:0] singleSig,
  input wire logic [3:0] measStart,
  input wire logic [3:0] measDone,
  input wire logic [3:0] class_done_flag,
  input wire logic [31:0] two_pair_power_limit,
  input wire logic [17:0] four_pair_power_limit
);
  logic [3:0] doneHist;
  logic [1:0] wrHist;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  // History of done pulses and acked writes
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      doneHist <= 4'h0;
      wrHist <= 2'h0;
    end else begin
      doneHist <= {doneHist[2:0], |measDone};
      wrHist <= {wrHist[0], wbAck && wbWe};
    end
  end
  sequence s_req;
    wbCyc && wbStb && !wbAck;
  endsequence
  sequence s_ackOnce;
    wbAck ##1 !wbAck;
  endsequence
  property p_ack;
    s_req |=> s_ackOnce;
  endproperty
  property p_unmapped;
    wbAck && !$past(wbWe) && $past(wbAdr) == 10'h100 |-> wbDatOut == 32'h0;
  endproperty
  property p_pwrWidth;
    wbAck && $past(wbAdr) >= 10'h144 && $past(wbAdr) <= 10'h150 |-> wbDatOut[31:7] == 25'h0;
  endproperty
  property p_flag;
    class_done_flag != 4'h0 |-> (class_done_flag & ~$past(grantStb)) == 4'h0;
  endproperty
  property p_startPulse;
    (measStart & $past(measStart)) == 4'h0;
  endproperty
  property p_startOn;
    (measStart & ~($past(chanOn) & $past(chanOn, 2))) == 4'h0;
  endproperty
  property p_ssPair;
    fourPairPort[0] && singleSig[0] |-> measStart[0] == measStart[1];
  endproperty
  property p_lim2;
    $changed(two_pair_power_limit) |-> doneHist != 4'h0 || wrHist != 2'h0;
  endproperty
  property p_lim4;
    $changed(four_pair_power_limit) |-> doneHist != 4'h0 || wrHist != 2'h0;
  endproperty
  a_ack: assert property (p_ack) else $error("ack not one cycle after request");
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  a_pwrWidth: assert property (p_pwrWidth) else $error("power read wider than 7 bits");
  a_flag: assert property (p_flag) else $error("done flag without grant");
  a_startPulse: assert property (p_startPulse) else $error("start longer than a pulse");
  a_startOn: assert property (p_startOn) else $error("start on unpowered channel");
  a_ssPair: assert property (p_ssPair) else $error("single signature pair split");
  a_lim2: assert property (p_lim2) else $error("two-pair limit moved unprompted");
  a_lim4: assert property (p_lim4) else $error("four-pair limit moved unprompted");
endmodule // aclp_ctrl_asserts

bind aclp_ctrl aclp_ctrl_asserts aclp_ctrl_asserts_i (.clk, .rst_b, .wbCyc, .wbStb, .wbWe,
  .wbAdr, .wbDatOut, .wbAck, .chanOn, .grantStb, .fourPairPort, .singleSig, .measStart,
  .measDone, .class_done_flag, .two_pair_power_limit, .four_pair_power_limit);

// file: test/tb_aclp_ctrl.sv
// Self-checking bench of the auto class power limit block.
// Assumes package, defines header and checker are compiled first.
`timescale 1ns/1ps
// ==========================================
// Bench top
module tb_aclp_ctrl;
  import aclp_pkg::*;
  logic clk, rst_b, wbCyc, wbStb, wbWe, wbAck;
  logic [9:0] wbAdr;
  logic [3:0] wbSel, chanOn, grantStb, reqClassZero, manualMode, semiAuto, discEn;
  logic [3:0] classEnable, alloc15w, oneFinger, measStart, measDone, class_done_flag;
  logic [31:0] wbDatIn, wbDatOut, two_pair_power_limit;
  logic [15:0] grantCode, threeFingerCode;
  logic [1:0] fourPairPort, singleSig;
  logic [27:0] measPower;
  logic [17:0] four_pair_power_limit;
  int n_errors = 0;
  int checked = 0;

  aclp_ctrl aclp_ctrl_i (.clk, .rst_b, .wbCyc, .wbStb, .wbWe, .wbAdr, .wbSel, .wbDatIn,
    .wbDatOut, .wbAck, .chanOn, .grantStb, .grantCode, .reqClassZero, .manualMode, .semiAuto,
    .discovery_enable(discEn), .classEnable, .alloc15w, .oneFinger, .threeFingerCode,
    .fourPairPort, .singleSig, .measStart, .measDone, .measPower, .class_done_flag,
    .two_pair_power_limit, .four_pair_power_limit);

  // Clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic final_report();
    $display("errors %0d checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // Classic single Wishbone cycle, held until ack is sampled
  task automatic wb(input logic we, input logic [7:0] idx, input logic [7:0] d,
                    input logic [3:0] s, output logic [31:0] q);
    int k;
    @(posedge clk);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= we;
    wbSel <= s;
    wbAdr <= {idx, 2'b00};
    wbDatIn <= {24'h0, d};
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (wbAck !== 1'b1);
    q = wbDatOut;
    chk("ackLatency", 32'(k), 32'd2);
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] idx, input logic [31:0] exp, input string what);
    logic [31:0] q;
    wb(1'b0, idx, 8'h0, 4'hf, q);
    chk(what, q, exp);
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [31:0] q;
    wb(1'b1, idx, d, 4'hf, q);
  endtask

  // Power plus banded margin, half-watt units
  function automatic logic [31:0] plusMargin(input logic [7:0] p);
    int b[9] = '{36, 52, 74, 90, 103, 116, 126, 136, 146};
    for (int i = 0; i < 9; i++) begin
      if (p <= b[i]) return {24'h0, p} + ((i == 0) ? 32'h1 : 32'(2 * i));
    end
    return {24'h0, p} + 32'h12;
  endfunction

  // Grant pulse, then done flag on the strobed channel only
  task automatic grant(input logic [3:0] m);
    @(posedge clk);
    grantStb <= m;
    @(posedge clk);
    grantStb <= 4'h0;
    @(posedge clk);
    chk("doneFlag", {28'h0, class_done_flag}, {28'h0, m});
  endtask

  // Request, wait for start, answer with a result
  task automatic measure(input logic [3:0] m, input logic [3:0] aac, input logic [27:0] p);
    int k;
    wr(8'h50, {m, aac});
    k = 0;
    while (measStart !== m && k < 10) begin
      @(posedge clk);
      k++;
    end
    chk("start", {28'h0, measStart}, {28'h0, m});
    measDone <= m;
    measPower <= p;
    @(posedge clk);
    measDone <= 4'h0;
    repeat (6) @(posedge clk);
  endtask

  task automatic tRegs();
    logic [31:0] q;
    rd(8'h50, 32'h0, "ctrlRst");
    rd(8'h58, 32'hff, "lim2Rst");
    rd(8'h5c, 32'h1ff, "lim4Rst");
    rd(8'h4c, 32'h0, "classRst");
    rd(8'h40, 32'h0, "unmapped");
    wb(1'b1, 8'h50, 8'h0f, 4'h0, q);
    rd(8'h50, 32'h0, "selOff");
    wr(8'h4c, 8'h33);
    rd(8'h4c, 32'h0, "classRo");
    wr(8'h50, 8'h0f);
    rd(8'h50, 32'h0f, "ctrlRw");
  endtask

  task automatic tClass();
    logic [3:0] a;
    for (int c = 0; c < 16; c++) begin
      grantCode <= {4'h0, 4'(c), 8'h0};
      threeFingerCode <= {4'h0, 4'(c), 8'h0};
      grant(4'h4);
      a = (c <= 4 || (c >= 8 && c <= 11) || c == 13) ? 4'(c) : 4'h0;
      rd(8'h4e, {24'h0, a, (c == 6) ? 4'h6 : a}, "class");
    end
    reqClassZero <= 4'h4;
    grant(4'h4);
    rd(8'h4e, 32'h30, "classZero");
    reqClassZero <= 4'h0;
    manualMode <= 4'h4;
    threeFingerCode <= 16'h0;
    grantCode <= 16'h0300;
    grant(4'h4);
    rd(8'h4e, 32'h0, "manual");
    manualMode <= 4'h0;
    alloc15w <= 4'h0;
    oneFinger <= 4'h0;
    threeFingerCode <= 16'h0200;
    grant(4'h4);
    rd(8'h4e, 32'h30, "prevKept");
    alloc15w <= 4'hf;
    oneFinger <= 4'hf;
    chanOn <= 4'h3;
    rd(8'h4e, 32'h0, "offClear");
    chanOn <= 4'h7;
    grant(4'h4);
  endtask

  task automatic tSsPair();
    int k;
    logic [3:0] seen;
    grantCode <= 16'h0008;
    threeFingerCode <= 16'h0;
    grant(4'h1);
    rd(8'h4d, 32'h80, "ssShared");
    wr(8'h58, 8'h40);
    wr(8'h50, 8'h11);
    seen = 4'h0;
    for (k = 0; k < 8; k++) begin
      @(posedge clk);
      seen = seen | measStart;
    end
    chk("oneReq", {28'h0, seen}, 32'h0);
    rd(8'h50, 32'h11, "reqHeld");
    measure(4'h3, 4'h1, {14'h0, 7'd30, 7'd20});
    rd(8'h5c, 32'd52, "lim4Sum");
    chk("lim4Port", {14'h0, four_pair_power_limit}, {14'h0, 9'h1ff, 9'd52});
    rd(8'h58, 32'h40, "lim2Kept");
    rd(8'h52, 32'd30, "pwr2");
    rd(8'h50, 32'h01, "reqClear");
  endtask

  task automatic tTwoPair();
    measure(4'h4, 4'h4, {7'd0, 7'd20, 14'h0});
    rd(8'h5a, 32'd21, "lim2Own");
    measure(4'h4, 4'h4, {7'd0, 7'd40, 14'h0});
    rd(8'h5a, 32'd21, "overClass");
    measure(4'h4, 4'h0, {7'd0, 7'd10, 14'h0});
    rd(8'h5a, 32'd21, "aacOff");
    chk("lim2Port", two_pair_power_limit, {8'hff, 8'd21, 8'hff, 8'h40});
  endtask

  task automatic tBands();
    logic [7:0] p[8] = '{8'd36, 8'd37, 8'd52, 8'd53, 8'd74, 8'd90, 8'd103, 8'd127};
    wr(8'h50, 8'h80);
    chanOn <= 4'hf;
    rd(8'h50, 32'h0, "preOnReq");
    fourPairPort <= 2'b11;
    grantCode <= 16'h1d00;
    grant(4'h4);
    rd(8'h4e, 32'hd0, "dsOwn");
    grantCode <= 16'h0000;
    grant(4'h8);
    rd(8'h4e, 32'hd0, "dsKept");
    for (int i = 0; i < 8; i++) begin
      measure(4'h8, 4'h8, {p[i][6:0], 21'h0});
      rd(8'h5b, plusMargin(p[i]), "band");
      rd(8'h54, {24'h0, p[i]}, "pwr4");
    end
  endtask

  // Main sequence
  initial begin
    {wbCyc, wbStb, wbWe} = 3'h0;
    wbAdr = 10'h0;
    wbSel = 4'h0;
    wbDatIn = 32'h0;
    {grantStb, reqClassZero, manualMode, measDone} = 16'h0;
    {semiAuto, discEn, classEnable, alloc15w, oneFinger} = 20'hfffff;
    chanOn = 4'h7;
    grantCode = 16'h0;
    threeFingerCode = 16'h0;
    fourPairPort = 2'b01;
    singleSig = 2'b01;
    measPower = 28'h0;
    rst_b = 1'b0;
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    tRegs();
    tClass();
    tSsPair();
    tTwoPair();
    tBands();
    final_report();
  end

  // Watchdog
  initial begin
    #200000;
    n_errors++;
    final_report();
  end
endmodule // tb_aclp_ctrl
